// >>> rtl/ciext_pkg.sv
// constants for the cursor, pop-up icon and extended crtc register bank
`default_nettype none
package ciext_pkg;
    // ************************************************************
    // i/o port addresses
    // ************************************************************
    localparam logic [15:0] SEQ_INDEX_PORT   = 16'h03c4;
    localparam logic [15:0] SEQ_DATA_PORT    = 16'h03c5;
    localparam logic [15:0] CRTC_INDEX_MONO  = 16'h03b4;
    localparam logic [15:0] CRTC_DATA_MONO   = 16'h03b5;
    localparam logic [15:0] CRTC_INDEX_COLOR = 16'h03d4;
    localparam logic [15:0] CRTC_DATA_COLOR  = 16'h03d5;

    // ************************************************************
    // sequencer indexes
    // ************************************************************
    localparam logic [7:0] IDX_ICON_X_LOW   = 8'h90;
    localparam logic [7:0] IDX_ICON_X_HIGH  = 8'h91;
    localparam logic [7:0] IDX_ICON_Y_LOW   = 8'h92;
    localparam logic [7:0] IDX_ICON_Y_HIGH  = 8'h93;
    localparam logic [7:0] IDX_CURSOR_X_LOW = 8'h88;
    localparam logic [7:0] IDX_CURSOR_X_HI  = 8'h89;
    localparam logic [7:0] IDX_CURSOR_Y_LOW = 8'h8a;
    localparam logic [7:0] IDX_CURSOR_Y_HI  = 8'h8b;
    localparam logic [7:0] IDX_CURSOR_FG    = 8'h8c;
    localparam logic [7:0] IDX_CURSOR_BG    = 8'h8d;

    // ************************************************************
    // crtc extension indexes
    // ************************************************************
    localparam logic [7:0] IDX_CRTC_OVERFLOW = 8'h30;
    localparam logic [7:0] IDX_RETRACE_POINT = 8'h31;
    localparam logic [7:0] IDX_TV_VDE_START  = 8'h32;
    localparam logic [7:0] IDX_TV_VDE_END_HI = 8'h33;
    localparam logic [7:0] IDX_TV_VDE_END_LO = 8'h34;

    // ************************************************************
    // writable-bit masks and field positions
    // ************************************************************
    localparam logic [7:0] MASK_HIGH3      = 8'h07;
    localparam logic [7:0] MASK_HIGH_CLIP  = 8'h0f;
    localparam logic [7:0] MASK_FULL       = 8'hff;
    localparam int         CLIP_SEL_BIT    = 3;
    localparam int         INTERLACE_BIT   = 7;
    localparam int         DSA_HI_MSB      = 6;
    localparam int         DSA_HI_LSB      = 4;
    localparam int         VT10_BIT        = 3;
    localparam int         VDE10_BIT       = 2;
    localparam int         VBS10_BIT       = 1;
    localparam int         VRS10_BIT       = 0;
    localparam int         DS_INTERLACE_BIT = 7;
    localparam int         HBLANK_END_MSB  = 6;
    localparam int         HBLANK_END_LSB  = 5;
    localparam int         VBLANK_END_MSB  = 4;
    localparam int         VBLANK_END_LSB  = 3;
    localparam int         CLIP_CNT_MSB    = 4;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage
`default_nettype wire

// >>> rtl/ciext_regs.sv
// cursor, pop-up icon and extended crtc indexed register bank
`default_nettype none
module ciext_regs (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] ioAddr,
    input  wire logic        ioWrEn,
    input  wire logic        ioRdEn,
    input  wire logic [7:0]  ioWrData,
    output logic      [7:0]  ioRdData,
    input  wire logic [10:0] crtVertCount,
    output logic      [10:0] iconXStart,
    output logic      [10:0] iconYStart,
    output logic      [10:0] cursorXOffset,
    output logic      [4:0]  cursorXHidden,
    output logic             cursorXClip,
    output logic      [10:0] cursorYOffset,
    output logic      [4:0]  cursorYHidden,
    output logic             cursorYClip,
    output logic      [23:0] cursorFgRgb,
    output logic      [23:0] cursorBgRgb,
    output logic             interlaceScanEnable,
    output logic      [2:0]  displayStartHigh,
    output logic             verticalTotalBit10,
    output logic             verticalDisplayEndBit10,
    output logic             verticalBlankStartBit10,
    output logic             verticalRetraceStartBit10,
    output logic      [7:0]  retracePoint,
    output logic             retracePointActive,
    output logic             doubleScanInterlaceEnable,
    output logic      [1:0]  horizontalBlankEndHigh,
    output logic      [1:0]  verticalBlankEndHigh,
    output logic             tvVertDisplayEnable
);
    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0]  seqIndex_q;
    logic [7:0]  crtcIndex_q;
    logic [7:0]  iconXLow_q;
    logic [7:0]  iconXHigh_q;
    logic [7:0]  iconYLow_q;
    logic [7:0]  iconYHigh_q;
    logic [7:0]  curXLow_q;
    logic [7:0]  curXHigh_q;
    logic [7:0]  curYLow_q;
    logic [7:0]  curYHigh_q;
    logic [7:0]  curFg_q;
    logic [7:0]  curBg_q;
    logic [7:0]  crtOverflow_q;
    logic [7:0]  retrace_q;
    logic [7:0]  vdeStart_q;
    logic [7:0]  vdeEndHigh_q;
    logic [7:0]  vdeEndLow_q;
    logic [7:0]  rdData_d;
    logic        seqWr;
    logic        crtcWr;
    logic        crtcIdxHit;
    logic        crtcDataHit;
    logic [10:0] vdeEnd;

    // ************************************************************
    // port decode
    // ************************************************************
    // both mono and colour crtc port pairs reach the same bank
    assign crtcIdxHit  = (ioAddr == ciext_pkg::CRTC_INDEX_MONO) ||
                         (ioAddr == ciext_pkg::CRTC_INDEX_COLOR);
    assign crtcDataHit = (ioAddr == ciext_pkg::CRTC_DATA_MONO) ||
                         (ioAddr == ciext_pkg::CRTC_DATA_COLOR);
    assign seqWr       = ioWrEn && (ioAddr == ciext_pkg::SEQ_DATA_PORT);
    assign crtcWr      = ioWrEn && crtcDataHit;

    // index latches
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            seqIndex_q  <= ciext_pkg::RESET_BYTE;
            crtcIndex_q <= ciext_pkg::RESET_BYTE;
        end else begin
            if (ioWrEn && ioAddr == ciext_pkg::SEQ_INDEX_PORT) begin
                seqIndex_q <= ioWrData;
            end
            if (ioWrEn && crtcIdxHit) begin
                crtcIndex_q <= ioWrData;
            end
        end
    end

    // ************************************************************
    // sequencer bank writes
    // ************************************************************
    // reserved bits are masked off so they always hold zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            iconXLow_q  <= ciext_pkg::RESET_BYTE;
            iconXHigh_q <= ciext_pkg::RESET_BYTE;
            iconYLow_q  <= ciext_pkg::RESET_BYTE;
            iconYHigh_q <= ciext_pkg::RESET_BYTE;
            curXLow_q   <= ciext_pkg::RESET_BYTE;
            curXHigh_q  <= ciext_pkg::RESET_BYTE;
            curYLow_q   <= ciext_pkg::RESET_BYTE;
            curYHigh_q  <= ciext_pkg::RESET_BYTE;
            curFg_q     <= ciext_pkg::RESET_BYTE;
            curBg_q     <= ciext_pkg::RESET_BYTE;
        end else if (seqWr) begin
            case (seqIndex_q)
                ciext_pkg::IDX_ICON_X_LOW: begin
                    iconXLow_q <= ioWrData;
                end
                ciext_pkg::IDX_ICON_X_HIGH: begin
                    iconXHigh_q <= ioWrData & ciext_pkg::MASK_HIGH3;
                end
                ciext_pkg::IDX_ICON_Y_LOW: begin
                    iconYLow_q <= ioWrData;
                end
                ciext_pkg::IDX_ICON_Y_HIGH: begin
                    iconYHigh_q <= ioWrData & ciext_pkg::MASK_HIGH3;
                end
                ciext_pkg::IDX_CURSOR_X_LOW: begin
                    curXLow_q <= ioWrData;
                end
                ciext_pkg::IDX_CURSOR_X_HI: begin
                    curXHigh_q <= ioWrData & ciext_pkg::MASK_HIGH_CLIP;
                end
                ciext_pkg::IDX_CURSOR_Y_LOW: begin
                    curYLow_q <= ioWrData;
                end
                ciext_pkg::IDX_CURSOR_Y_HI: begin
                    curYHigh_q <= ioWrData & ciext_pkg::MASK_HIGH_CLIP;
                end
                ciext_pkg::IDX_CURSOR_FG: begin
                    curFg_q <= ioWrData;
                end
                ciext_pkg::IDX_CURSOR_BG: begin
                    curBg_q <= ioWrData;
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // crtc extension writes
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            crtOverflow_q <= ciext_pkg::RESET_BYTE;
            retrace_q     <= ciext_pkg::RESET_BYTE;
            vdeStart_q    <= ciext_pkg::RESET_BYTE;
            vdeEndHigh_q  <= ciext_pkg::RESET_BYTE;
            vdeEndLow_q   <= ciext_pkg::RESET_BYTE;
        end else if (crtcWr) begin
            case (crtcIndex_q)
                ciext_pkg::IDX_CRTC_OVERFLOW: begin
                    crtOverflow_q <= ioWrData & ciext_pkg::MASK_FULL;
                end
                ciext_pkg::IDX_RETRACE_POINT: begin
                    retrace_q <= ioWrData;
                end
                ciext_pkg::IDX_TV_VDE_START: begin
                    vdeStart_q <= ioWrData;
                end
                ciext_pkg::IDX_TV_VDE_END_HI: begin
                    vdeEndHigh_q <= ioWrData;
                end
                ciext_pkg::IDX_TV_VDE_END_LO: begin
                    vdeEndLow_q <= ioWrData;
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // read back
    // ************************************************************
    // read mux; unmapped indexes and other ports read zero
    always_comb begin
        rdData_d = ciext_pkg::RESET_BYTE;
        if (ioAddr == ciext_pkg::SEQ_INDEX_PORT) begin
            rdData_d = seqIndex_q;
        end else if (crtcIdxHit) begin
            rdData_d = crtcIndex_q;
        end else if (ioAddr == ciext_pkg::SEQ_DATA_PORT) begin
            case (seqIndex_q)
                ciext_pkg::IDX_ICON_X_LOW:   rdData_d = iconXLow_q;
                ciext_pkg::IDX_ICON_X_HIGH:  rdData_d = iconXHigh_q;
                ciext_pkg::IDX_ICON_Y_LOW:   rdData_d = iconYLow_q;
                ciext_pkg::IDX_ICON_Y_HIGH:  rdData_d = iconYHigh_q;
                ciext_pkg::IDX_CURSOR_X_LOW: rdData_d = curXLow_q;
                ciext_pkg::IDX_CURSOR_X_HI:  rdData_d = curXHigh_q;
                ciext_pkg::IDX_CURSOR_Y_LOW: rdData_d = curYLow_q;
                ciext_pkg::IDX_CURSOR_Y_HI:  rdData_d = curYHigh_q;
                ciext_pkg::IDX_CURSOR_FG:    rdData_d = curFg_q;
                ciext_pkg::IDX_CURSOR_BG:    rdData_d = curBg_q;
                default:                     rdData_d = ciext_pkg::RESET_BYTE;
            endcase
        end else if (crtcDataHit) begin
            case (crtcIndex_q)
                ciext_pkg::IDX_CRTC_OVERFLOW: rdData_d = crtOverflow_q;
                ciext_pkg::IDX_RETRACE_POINT: rdData_d = retrace_q;
                ciext_pkg::IDX_TV_VDE_START:  rdData_d = vdeStart_q;
                ciext_pkg::IDX_TV_VDE_END_HI: rdData_d = vdeEndHigh_q;
                ciext_pkg::IDX_TV_VDE_END_LO: rdData_d = vdeEndLow_q;
                default:                      rdData_d = ciext_pkg::RESET_BYTE;
            endcase
        end
    end

    // read data lands one cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ioRdData <= ciext_pkg::RESET_BYTE;
        end else if (ioRdEn) begin
            ioRdData <= rdData_d;
        end
    end

    // ************************************************************
    // icon and cursor position outputs
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            iconXStart <= 11'h000;
            iconYStart <= 11'h000;
        end else begin
            iconXStart <= {iconXHigh_q[2:0], iconXLow_q};
            iconYStart <= {iconYHigh_q[2:0], iconYLow_q};
        end
    end

    // clip select picks offset form or hidden-pixel count form
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cursorXOffset <= 11'h000;
            cursorXHidden <= 5'h00;
            cursorXClip   <= 1'b0;
            cursorYOffset <= 11'h000;
            cursorYHidden <= 5'h00;
            cursorYClip   <= 1'b0;
        end else begin
            cursorXClip   <= curXHigh_q[ciext_pkg::CLIP_SEL_BIT];
            cursorYClip   <= curYHigh_q[ciext_pkg::CLIP_SEL_BIT];
            cursorXOffset <= curXHigh_q[ciext_pkg::CLIP_SEL_BIT] ? 11'h000
                             : {curXHigh_q[2:0], curXLow_q};
            cursorXHidden <= curXHigh_q[ciext_pkg::CLIP_SEL_BIT]
                             ? curXLow_q[ciext_pkg::CLIP_CNT_MSB:0] : 5'h00;
            cursorYOffset <= curYHigh_q[ciext_pkg::CLIP_SEL_BIT] ? 11'h000
                             : {curYHigh_q[2:0], curYLow_q};
            cursorYHidden <= curYHigh_q[ciext_pkg::CLIP_SEL_BIT]
                             ? curYLow_q[ciext_pkg::CLIP_CNT_MSB:0] : 5'h00;
        end
    end

    // ************************************************************
    // colour expansion
    // ************************************************************
    // 3:3:2 to 8:8:8 by bit replication so full scale maps to ff
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cursorFgRgb <= 24'h00_0000;
            cursorBgRgb <= 24'h00_0000;
        end else begin
            cursorFgRgb <= {curFg_q[7:5], curFg_q[7:5], curFg_q[7:6],
                            curFg_q[4:2], curFg_q[4:2], curFg_q[4:3],
                            {4{curFg_q[1:0]}}};
            cursorBgRgb <= {curBg_q[7:5], curBg_q[7:5], curBg_q[7:6],
                            curBg_q[4:2], curBg_q[4:2], curBg_q[4:3],
                            {4{curBg_q[1:0]}}};
        end
    end

    // ************************************************************
    // crtc extension outputs
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            interlaceScanEnable       <= 1'b0;
            displayStartHigh          <= 3'h0;
            verticalTotalBit10        <= 1'b0;
            verticalDisplayEndBit10   <= 1'b0;
            verticalBlankStartBit10   <= 1'b0;
            verticalRetraceStartBit10 <= 1'b0;
            retracePoint              <= 8'h00;
            retracePointActive        <= 1'b0;
            doubleScanInterlaceEnable <= 1'b0;
            horizontalBlankEndHigh    <= 2'h0;
            verticalBlankEndHigh      <= 2'h0;
        end else begin
            interlaceScanEnable       <= crtOverflow_q[ciext_pkg::INTERLACE_BIT];
            displayStartHigh          <= crtOverflow_q[ciext_pkg::DSA_HI_MSB:
                                                       ciext_pkg::DSA_HI_LSB];
            verticalTotalBit10        <= crtOverflow_q[ciext_pkg::VT10_BIT];
            verticalDisplayEndBit10   <= crtOverflow_q[ciext_pkg::VDE10_BIT];
            verticalBlankStartBit10   <= crtOverflow_q[ciext_pkg::VBS10_BIT];
            verticalRetraceStartBit10 <= crtOverflow_q[ciext_pkg::VRS10_BIT];
            retracePoint              <= retrace_q;
            retracePointActive        <= crtOverflow_q[ciext_pkg::INTERLACE_BIT];
            doubleScanInterlaceEnable <= vdeEndHigh_q[ciext_pkg::DS_INTERLACE_BIT];
            horizontalBlankEndHigh    <= vdeEndHigh_q[ciext_pkg::HBLANK_END_MSB:
                                                      ciext_pkg::HBLANK_END_LSB];
            verticalBlankEndHigh      <= vdeEndHigh_q[ciext_pkg::VBLANK_END_MSB:
                                                      ciext_pkg::VBLANK_END_LSB];
        end
    end

    // ************************************************************
    // tv vertical display enable window
    // ************************************************************
    assign vdeEnd = {vdeEndHigh_q[2:0], vdeEndLow_q};

    // end match wins when start and end land on the same line
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tvVertDisplayEnable <= 1'b0;
        end else if (crtVertCount == vdeEnd) begin
            tvVertDisplayEnable <= 1'b0;
        end else if (crtVertCount == {3'h0, vdeStart_q}) begin
            tvVertDisplayEnable <= 1'b1;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_icon_x_high: assert property (
        seqWr && seqIndex_q == ciext_pkg::IDX_ICON_X_HIGH |->
            ##2 iconXStart[10:8] == $past(ioWrData[2:0], 2))
        else $error("icon x high bits not taken from write");
    a_cursor_x_offset: assert property (
        !curXHigh_q[ciext_pkg::CLIP_SEL_BIT] |=>
            cursorXOffset == $past({curXHigh_q[2:0], curXLow_q}) && cursorXHidden == 5'h00)
        else $error("cursor x offset form wrong");
    a_cursor_x_hidden: assert property (
        curXHigh_q[ciext_pkg::CLIP_SEL_BIT] |=>
            cursorXHidden == $past(curXLow_q[4:0]) && cursorXClip)
        else $error("cursor x hidden count wrong");
    a_cursor_y_hidden: assert property (
        curYHigh_q[ciext_pkg::CLIP_SEL_BIT] |=>
            cursorYHidden == $past(curYLow_q[4:0]) && cursorYOffset == 11'h000)
        else $error("cursor y hidden count wrong");
    a_fg_expand: assert property (
        seqWr && seqIndex_q == ciext_pkg::IDX_CURSOR_FG && ioWrData == 8'hff |->
            ##2 cursorFgRgb == 24'hff_ffff)
        else $error("foreground white does not expand to full scale");
    a_interlace_bit: assert property (
        crtcWr && crtcIndex_q == ciext_pkg::IDX_CRTC_OVERFLOW |->
            ##2 interlaceScanEnable == $past(ioWrData[7], 2)
                && displayStartHigh == $past(ioWrData[6:4], 2))
        else $error("overflow register fields not applied");
    a_tv_vde_rise: assert property (
        crtVertCount == {3'h0, vdeStart_q} && crtVertCount != vdeEnd |=> tvVertDisplayEnable)
        else $error("tv display enable did not rise at start line");
    a_tv_vde_fall: assert property (
        crtVertCount == vdeEnd |=> !tvVertDisplayEnable)
        else $error("tv display enable did not fall at end line");
    a_reserved_zero: assert property (
        seqWr && seqIndex_q == ciext_pkg::IDX_CURSOR_Y_HI |=> curYHigh_q[7:4] == 4'h0)
        else $error("reserved cursor bits kept a written value");
    a_blank_ext: assert property (
        crtcWr && crtcIndex_q == ciext_pkg::IDX_TV_VDE_END_HI |->
            ##2 verticalBlankEndHigh == $past(ioWrData[4:3], 2)
                && horizontalBlankEndHigh == $past(ioWrData[6:5], 2))
        else $error("blank end extension bits not applied");
endmodule
`default_nettype wire

// >>> verification/ciext_regs_tb_top.sv
// self-checking bench for the cursor, icon and extended crtc register bank
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module ciext_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    localparam logic [15:0] SQ = ciext_pkg::SEQ_INDEX_PORT;
    localparam logic [15:0] CC = ciext_pkg::CRTC_INDEX_COLOR;
    localparam logic [15:0] CM = ciext_pkg::CRTC_INDEX_MONO;
    logic        sys_clk, rst_b, ioWrEn, ioRdEn;
    logic [15:0] ioAddr;
    logic [7:0]  ioWrData, ioRdData, retracePoint;
    logic [10:0] crtVertCount, iconXStart, iconYStart, cursorXOffset, cursorYOffset;
    logic [4:0]  cursorXHidden, cursorYHidden;
    logic [23:0] cursorFgRgb, cursorBgRgb;
    logic [2:0]  displayStartHigh;
    logic [1:0]  horizontalBlankEndHigh, verticalBlankEndHigh;
    logic        cursorXClip, cursorYClip, interlaceScanEnable, verticalTotalBit10;
    logic        verticalDisplayEndBit10, verticalBlankStartBit10, verticalRetraceStartBit10;
    logic        retracePointActive, doubleScanInterlaceEnable, tvVertDisplayEnable;
    int          err_total, comparisons;

    ciext_regs uut (.sys_clk, .rst_b, .ioAddr, .ioWrEn, .ioRdEn, .ioWrData, .ioRdData,
        .crtVertCount, .iconXStart, .iconYStart, .cursorXOffset, .cursorXHidden, .cursorXClip,
        .cursorYOffset, .cursorYHidden, .cursorYClip, .cursorFgRgb, .cursorBgRgb,
        .interlaceScanEnable, .displayStartHigh, .verticalTotalBit10, .verticalDisplayEndBit10,
        .verticalBlankStartBit10, .verticalRetraceStartBit10, .retracePoint,
        .retracePointActive, .doubleScanInterlaceEnable, .horizontalBlankEndHigh,
        .verticalBlankEndHigh, .tvVertDisplayEnable);

    // one write strobe held across a single taking edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        ioAddr   <= a;
        ioWrData <= d;
        ioWrEn   <= 1'b1;
        @(posedge sys_clk);
        ioWrEn   <= 1'b0;
    endtask
    // index then data; p is the index port of the pair
    task automatic put(input logic [15:0] p, input logic [7:0] i, input logic [7:0] d);
        wr(p, i);
        wr(p + 16'h0001, d);
    endtask
    // read strobe, data compared once the taking edge has landed
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        ioAddr <= a;
        ioRdEn <= 1'b1;
        @(posedge sys_clk);
        ioRdEn <= 1'b0;
        @(negedge sys_clk);
        `CHK(ioRdData, exp)
    endtask
    task automatic get(input logic [15:0] p, input logic [7:0] i, input logic [7:0] exp);
        wr(p, i);
        rd(p + 16'h0001, exp);
    endtask
    // derived outputs move one edge after the write edge
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // line count applied, enable compared one edge later
    task automatic tv(input logic [10:0] v, input logic exp);
        @(posedge sys_clk);
        crtVertCount <= v;
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(tvVertDisplayEnable, exp)
    endtask
    task automatic end_of_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst_b = 1'b0;
        ioAddr = 16'h0000;
        ioWrEn = 1'b0;
        ioRdEn = 1'b0;
        ioWrData = 8'h00;
        crtVertCount = 11'h000;
        err_total = 0;
        comparisons = 0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        `CHK(interlaceScanEnable, 1'b0)
        get(CC, 8'h30, 8'h00);
        put(SQ, 8'h90, 8'h12);
        put(SQ, 8'h91, 8'hff);
        put(SQ, 8'h92, 8'h34);
        put(SQ, 8'h93, 8'hfa);
        settle();
        `CHK(iconXStart, 11'h712)
        `CHK(iconYStart, 11'h234)
        get(SQ, 8'h91, 8'h07);
        get(SQ, 8'h93, 8'h02);
        put(SQ, 8'h88, 8'hf6);
        put(SQ, 8'h89, 8'hfd);
        put(SQ, 8'h8a, 8'h3b);
        put(SQ, 8'h8b, 8'h08);
        settle();
        `CHK({cursorXClip, cursorXHidden, cursorXOffset}, {1'b1, 5'h16, 11'h000})
        `CHK({cursorYClip, cursorYHidden, cursorYOffset}, {1'b1, 5'h1b, 11'h000})
        get(SQ, 8'h89, 8'h0d);
        put(SQ, 8'h89, 8'h05);
        put(SQ, 8'h8b, 8'hf7);
        settle();
        `CHK({cursorXClip, cursorXHidden, cursorXOffset}, {1'b0, 5'h00, 11'h5f6})
        `CHK({cursorYClip, cursorYHidden, cursorYOffset}, {1'b0, 5'h00, 11'h73b})
        get(SQ, 8'h8b, 8'h07);
        put(SQ, 8'h8c, 8'he5);
        put(SQ, 8'h8d, 8'h4a);
        settle();
        `CHK(cursorFgRgb, 24'hff_2455)
        `CHK(cursorBgRgb, 24'h49_49aa)
        put(SQ, 8'h8c, 8'hff);
        settle();
        `CHK(cursorFgRgb, 24'hff_ffff)
        put(CC, 8'h30, 8'hd5);
        put(CM, 8'h31, 8'h3c);
        settle();
        `CHK({interlaceScanEnable, displayStartHigh, verticalTotalBit10, verticalDisplayEndBit10,
            verticalBlankStartBit10, verticalRetraceStartBit10}, 8'hd5)
        `CHK({retracePointActive, retracePoint}, 9'h13c)
        // mid-run reset clears the interlace controls again
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        `CHK({interlaceScanEnable, retracePointActive, retracePoint}, 10'h000)
        get(CC, 8'h30, 8'h00);
        put(CC, 8'h30, 8'h2a);
        settle();
        `CHK({interlaceScanEnable, displayStartHigh, verticalTotalBit10, verticalDisplayEndBit10,
            verticalBlankStartBit10, verticalRetraceStartBit10}, 8'h2a)
        `CHK(retracePointActive, 1'b0)
        put(CC, 8'h32, 8'h05);
        put(CC, 8'h33, 8'hb1);
        put(CC, 8'h34, 8'h02);
        settle();
        `CHK({doubleScanInterlaceEnable, horizontalBlankEndHigh, verticalBlankEndHigh},
            5'h16)
        get(CC, 8'h33, 8'hb1);
        tv(11'h004, 1'b0);
        tv(11'h005, 1'b1);
        tv(11'h101, 1'b1);
        tv(11'h102, 1'b0);
        put(SQ, 8'h55, 8'hab);
        get(SQ, 8'h55, 8'h00);
        rd(16'h0300, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
